// File: verilog/interface_option_control.sv
// Serial interface option register with integrity monitor and result framing
`timescale 1ns/10ps
// Behaviour
// - Option register at 0x02, resets to zero.
// - Reserved bits read zero, host writes zero.
// - Bit 12 turns sync pin into conversion gate.
// - Bit 7 enables continuous result readout.
// - Bit 6 appends status to result reads.
// - Bit 5 monitors checked registers, flags changes.
// - Writing bit 5 zero clears error flag.
// - Option, result, status registers are unchecked.
// - Changing checked register while armed raises error.
// - Nonzero check field adds one check byte.
// - 00 off; 01 xor reads, crc writes.
// - Check field 10 selects crc both ways.
// - Bit 0 shortens result to 16 bits.
// - Signature register XORs registers, zero when disabled.
// - Continuous conversion is mode code 000.
module interface_option_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  output logic [23:0] rdata,
  output logic rd_valid,
  output logic addr_hit,
  input wire logic [23:0] checked_xor,
  output logic integrity_error,
  input wire logic [2:0] adc_mode,
  input wire logic sync_pin,
  output logic conversion_gate,
  output logic sync_normal,
  output logic cont_readout_active,
  output logic dout_reset_en,
  output logic drive_strength,
  output logic extra_check_byte,
  output logic read_check_xor,
  output logic read_check_crc,
  output logic write_check_crc,
  input wire logic result_valid,
  input wire logic [23:0] result_data,
  input wire logic [7:0] status_byte,
  output iface_option_pkg::result_word_t result_out,
  output logic result_ready
);
  import iface_option_pkg::*;

  // =====================================================
  // Option register
  logic [15:0] opt_reg;
  logic [15:0] opt_next;
  option_fields_t opt;
  wire opt_wr = wr_en && (addr == OPT_ADDR);
  wire sig_sel = addr == SIG_ADDR;
  wire opt_sel = addr == OPT_ADDR;

  // Reserved bits are forced to zero on every write
  assign opt_next = opt_wr ? (wdata & ~OPT_RSVD_MASK) : opt_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opt_reg <= OPT_RESET;
    end else begin
      opt_reg <= opt_next;
    end
  end

  // Field decode
  assign opt.sync_gate = opt_reg[SYNC_GATE_BIT];
  assign opt.drive_strength = opt_reg[DRIVE_BIT];
  assign opt.dout_reset = opt_reg[DOUT_RESET_BIT];
  assign opt.cont_read = opt_reg[CONT_READ_BIT];
  assign opt.status_append = opt_reg[STAT_APPEND_BIT];
  assign opt.integrity_en = opt_reg[INTEGRITY_BIT];
  assign opt.check = check_mode_t'(opt_reg[CHECK_LSB +: 2]);
  assign opt.short_width = opt_reg[SHORT_WIDTH_BIT];

  // =====================================================
  // Sync pin: three stages, change accepted once stages two and three agree
  // Stage one may still be settling, so only stages two and three vote
  logic [SYNC_STAGES-1:0] sync_sh_reg;
  logic sync_level_reg;
  wire stages_agree = sync_sh_reg[1] == sync_sh_reg[2];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_sh_reg <= '0;
      sync_level_reg <= 1'b0;
    end else begin
      sync_sh_reg <= {sync_sh_reg[SYNC_STAGES-2:0], sync_pin};
      if (stages_agree) begin
        sync_level_reg <= sync_sh_reg[2];
      end
    end
  end

  // Pin role steered by the alternate-function bit
  assign conversion_gate = opt.sync_gate & sync_level_reg;
  assign sync_normal = ~opt.sync_gate & sync_level_reg;

  // =====================================================
  // Mode outputs
  assign cont_readout_active = opt.cont_read && (adc_mode == MODE_CONTINUOUS);
  assign dout_reset_en = opt.dout_reset;
  assign drive_strength = opt.drive_strength;
  assign extra_check_byte = opt.check != CHECK_OFF;
  assign read_check_xor = opt.check == CHECK_XOR_READ;
  assign read_check_crc = opt.check[1];
  assign write_check_crc = opt.check != CHECK_OFF;

  // =====================================================
  // Integrity monitor
  // A checked write that leaves the XOR image unchanged goes unseen
  // Disable write beats a change in the same cycle: monitoring stops
  monitor_state_t mon_state_reg;
  monitor_state_t mon_state_next;
  logic [23:0] snapshot_reg;
  wire arm_write = opt_wr && wdata[INTEGRITY_BIT] && !opt.integrity_en;
  wire disarm_write = opt_wr && !wdata[INTEGRITY_BIT];
  // Checked image excludes option, result and status registers
  wire mismatch = checked_xor != snapshot_reg;

  always_comb begin
    mon_state_next = mon_state_reg;
    case (mon_state_reg)
      MON_IDLE: begin
        if (arm_write) begin
          mon_state_next = MON_ARMED;
        end
      end
      MON_ARMED: begin
        if (disarm_write) begin
          mon_state_next = MON_IDLE;
        end else if (mismatch) begin
          mon_state_next = MON_FAULT;
        end
      end
      MON_FAULT: begin
        if (disarm_write) begin
          mon_state_next = MON_IDLE;
        end
      end
      default: begin
        mon_state_next = MON_IDLE;
      end
    endcase
  end

  // Snapshot taken at the arming write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mon_state_reg <= MON_IDLE;
      snapshot_reg <= SIG_RESET;
    end else begin
      mon_state_reg <= mon_state_next;
      if (arm_write) begin
        snapshot_reg <= checked_xor;
      end
    end
  end

  assign integrity_error = mon_state_reg == MON_FAULT;
  // Signature reads zero while disabled
  wire [23:0] signature = opt.integrity_en ? checked_xor : SIG_RESET;

  // =====================================================
  // Register reads, one cycle latency
  wire [23:0] read_mux = opt_sel ? {8'h00, opt_reg} : (sig_sel ? signature : 24'h000000);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 24'h000000;
      rd_valid <= 1'b0;
      addr_hit <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      addr_hit <= rd_en && (opt_sel || sig_sel);
      if (rd_en) begin
        rdata <= read_mux;
      end
    end
  end

  // =====================================================
  // Result framing: width and status append fixed at each new result
  wire [23:0] payload = opt.short_width ? {8'h00, result_data[23:8]} : result_data;
  wire [5:0] base_len = opt.short_width ? LEN_SHORT : LEN_LONG;
  wire [31:0] framed = opt.status_append ? {payload, status_byte} : {8'h00, payload};
  wire [5:0] framed_len = opt.status_append ? 6'(base_len + LEN_STATUS) : base_len;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result_out <= '0;
      result_ready <= 1'b0;
    end else begin
      result_ready <= result_valid;
      if (result_valid) begin
        result_out <= '{word: framed, length: framed_len};
      end
    end
  end

  // =====================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence arm_seq;
    arm_write;
  endsequence
  sequence fault_seq;
    (mon_state_reg == MON_ARMED) && mismatch && !disarm_write;
  endsequence

  reserved_zero_a: assert property (1 |-> (opt_reg & OPT_RSVD_MASK) == 16'h0000)
    else $error("reserved option bits not zero");
  opt_write_a: assert property (opt_wr |=> opt_reg == $past(wdata & ~OPT_RSVD_MASK))
    else $error("option write not stored");
  gate_route_a: assert property (sync_level_reg && opt.sync_gate |-> conversion_gate && !sync_normal)
    else $error("sync pin not gating conversions");
  cont_read_a: assert property (cont_readout_active |-> adc_mode == MODE_CONTINUOUS && opt.cont_read)
    else $error("continuous readout outside continuous mode");
  arm_then_fault_a: assert property (arm_seq ##1 fault_seq |=> integrity_error)
    else $error("change while armed not flagged");
  clear_error_a: assert property (integrity_error && disarm_write |=> !integrity_error[*2])
    else $error("error not cleared by disable");
  sig_zero_a: assert property (!opt.integrity_en |-> signature == 24'h000000)
    else $error("signature not zero while disabled");
  check_byte_a: assert property (opt.check == CHECK_CRC_BOTH |-> read_check_crc && write_check_crc && extra_check_byte)
    else $error("crc both ways not selected");
  xor_read_a: assert property (opt.check == CHECK_XOR_READ |-> read_check_xor && !read_check_crc && write_check_crc)
    else $error("xor read mode wrong");
  short_len_a: assert property (result_valid && opt.short_width && !opt.status_append |=> result_out.length == LEN_SHORT)
    else $error("short result length wrong");
  append_a: assert property (result_valid && opt.status_append |=> result_out.word[7:0] == $past(status_byte))
    else $error("status not appended");
  dout_a: assert property (dout_reset_en == opt_reg[DOUT_RESET_BIT] && $stable(dout_reset_en) || $past(opt_wr))
    else $error("data-out reset enable changed without write");

  // Register read path
  sequence opt_read_seq;
    rd_en && opt_sel;
  endsequence
  sequence sig_read_seq;
    rd_en && sig_sel;
  endsequence
  sequence stray_read_seq;
    rd_en && !opt_sel && !sig_sel;
  endsequence

  read_valid_a: assert property (rd_en |=> rd_valid)
    else $error("read not answered in the next cycle");
  hit_flag_a: assert property (rd_en |=> addr_hit == $past(opt_sel || sig_sel))
    else $error("address hit flag wrong");
  opt_read_a: assert property (opt_read_seq |=> rdata == {8'h00, $past(opt_reg)})
    else $error("option read data wrong");
  sig_read_a: assert property (sig_read_seq |=> rdata == $past(signature))
    else $error("signature read data wrong");
  stray_read_a: assert property (stray_read_seq |=> !addr_hit && rdata == 24'h000000)
    else $error("unmapped read not zero");

  // Integrity monitor steps
  sequence disarm_seq;
    disarm_write;
  endsequence
  sequence calm_seq;
    (mon_state_reg == MON_ARMED) && !mismatch;
  endsequence

  arm_state_a: assert property (arm_seq |=> mon_state_reg == MON_ARMED)
    else $error("arming write did not arm the monitor");
  change_flag_a: assert property (fault_seq |=> integrity_error)
    else $error("checked register change not flagged");
  no_false_a: assert property (calm_seq |=> !integrity_error)
    else $error("error raised without a checked change");
  disarm_idle_a: assert property (disarm_seq |=> mon_state_reg == MON_IDLE)
    else $error("disable write did not stop the monitor");
  off_no_error_a: assert property (!opt.integrity_en |-> !integrity_error)
    else $error("error flag set while monitor disabled");
  snapshot_hold_a: assert property (mon_state_reg != MON_IDLE |=> $stable(snapshot_reg))
    else $error("snapshot moved while monitoring");

  // Pin synchroniser and routing
  sync_hold_a: assert property (!stages_agree |=> $stable(sync_level_reg))
    else $error("sync level moved before stages agreed");
  sync_take_a: assert property (stages_agree |=> sync_level_reg == $past(sync_sh_reg[2]))
    else $error("sync level not taken from last stage");
  normal_pin_a: assert property (!opt.sync_gate |-> sync_normal == sync_level_reg)
    else $error("sync pin lost its normal role");
  gate_off_a: assert property (!opt.sync_gate |-> !conversion_gate)
    else $error("conversion gate active with alternate role off");

  // Result framing steps
  sequence long_seq;
    result_valid && !opt.short_width && !opt.status_append;
  endsequence
  sequence short_seq;
    result_valid && opt.short_width && !opt.status_append;
  endsequence

  result_pulse_a: assert property (result_valid |=> result_ready)
    else $error("result not framed in the next cycle");
  long_len_a: assert property (long_seq |=> result_out.length == LEN_LONG)
    else $error("long result length wrong");
  short_word_a: assert property (short_seq |=>
    result_out.word == {16'h0000, $past(result_data[23:8])})
    else $error("short result word wrong");

  // Check field and readout mode
  check_off_a: assert property (opt.check == CHECK_OFF |->
    {extra_check_byte, read_check_xor, read_check_crc, write_check_crc} == 4'h0)
    else $error("check outputs active with checking off");
  cont_off_a: assert property (adc_mode != MODE_CONTINUOUS |-> !cont_readout_active)
    else $error("continuous readout outside continuous mode");
endmodule

// File: verilog/iface_option_pkg.sv
// Constants and types for the serial interface option register block
package iface_option_pkg;
  // =====================================================
  // Register map
  localparam logic [7:0] OPT_ADDR = 8'h02;
  localparam logic [7:0] SIG_ADDR = 8'h03;
  localparam logic [15:0] OPT_RESET = 16'h0000;
  localparam logic [23:0] SIG_RESET = 24'h000000;
  // Reserved bits 15:13, 10:9 and 4
  localparam logic [15:0] OPT_RSVD_MASK = 16'hE610;
  // =====================================================
  // Field positions
  localparam int SYNC_GATE_BIT = 12;
  localparam int DRIVE_BIT = 11;
  localparam int DOUT_RESET_BIT = 8;
  localparam int CONT_READ_BIT = 7;
  localparam int STAT_APPEND_BIT = 6;
  localparam int INTEGRITY_BIT = 5;
  localparam int CHECK_LSB = 2;
  localparam int SHORT_WIDTH_BIT = 0;
  // =====================================================
  // Converter mode code for continuous conversion
  localparam logic [2:0] MODE_CONTINUOUS = 3'h0;
  // Result lengths in bits
  localparam logic [5:0] LEN_SHORT = 6'h10;
  localparam logic [5:0] LEN_LONG = 6'h18;
  localparam logic [5:0] LEN_STATUS = 6'h08;
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;
  // =====================================================
  // Types
  typedef enum logic [1:0] {
    CHECK_OFF = 2'b00,
    CHECK_XOR_READ = 2'b01,
    CHECK_CRC_BOTH = 2'b10,
    CHECK_RSVD = 2'b11
  } check_mode_t;
  typedef enum logic [1:0] {
    MON_IDLE = 2'b00,
    MON_ARMED = 2'b01,
    MON_FAULT = 2'b10
  } monitor_state_t;
  typedef struct packed {
    logic sync_gate;
    logic drive_strength;
    logic dout_reset;
    logic cont_read;
    logic status_append;
    logic integrity_en;
    check_mode_t check;
    logic short_width;
  } option_fields_t;
  typedef struct packed {
    logic [31:0] word;
    logic [5:0] length;
  } result_word_t;
endpackage

// File: tb/checked_reg_model.sv
// Model of the checked user registers that feed the integrity monitor
`timescale 1ns/10ps
module checked_reg_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr,
  input wire logic [23:0] wdata,
  output logic [23:0] checked_xor
);
  // =====================================================
  // Storage
  logic [23:0] user_reg;
  // Bench writes these both before arming and while monitoring is armed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      user_reg <= 24'h000000;
    end else if (wr) begin
      user_reg <= wdata;
    end
  end
  // Signature of the checked bank, mixed with a fixed second register
  assign checked_xor = user_reg ^ 24'h0F0000;
endmodule

// File: tb/interface_option_control_tb_top.sv
// Self-checking bench for the interface option register
`timescale 1ns/10ps
module interface_option_control_tb_top;
  import iface_option_pkg::*;
  logic clk = 0, reset = 1, wr_en = 0, rd_en = 0, sync_pin = 0;
  logic [7:0] addr = 8'h00, status_byte = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [23:0] rdata, checked_xor, result_data = 24'h000000, ureg_d = 24'h000000;
  logic [2:0] adc_mode = 3'h0;
  logic rd_valid, addr_hit, integrity_error, conversion_gate, sync_normal, cont_readout_active;
  logic dout_reset_en, drive_strength, extra_check_byte, read_check_xor, read_check_crc;
  logic write_check_crc, result_valid = 0, result_ready, ureg_wr = 0;
  result_word_t result_out;
  int failures = 0, total_checks = 0;
  // =====================================================
  // Clock and instances
  always #20 clk = ~clk;
  interface_option_control i_dut (.clk(clk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .addr_hit(addr_hit),
    .checked_xor(checked_xor), .integrity_error(integrity_error), .adc_mode(adc_mode),
    .sync_pin(sync_pin), .conversion_gate(conversion_gate), .sync_normal(sync_normal),
    .cont_readout_active(cont_readout_active), .dout_reset_en(dout_reset_en),
    .drive_strength(drive_strength), .extra_check_byte(extra_check_byte),
    .read_check_xor(read_check_xor), .read_check_crc(read_check_crc),
    .write_check_crc(write_check_crc), .result_valid(result_valid),
    .result_data(result_data), .status_byte(status_byte), .result_out(result_out),
    .result_ready(result_ready));
  checked_reg_model i_model (.clk(clk), .reset(reset), .wr(ureg_wr), .wdata(ureg_d),
    .checked_xor(checked_xor));
  // =====================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(negedge clk);
    wr_en = 1;
    addr = OPT_ADDR;
    wdata = d;
    @(negedge clk);
    wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] exp, input logic hit);
    @(negedge clk);
    rd_en = 1;
    addr = a;
    @(negedge clk);
    rd_en = 0;
    chk(rd_valid, 1);
    chk(addr_hit, hit);
    chk(rdata, exp);
  endtask
  task automatic res(input logic [31:0] w, input logic [5:0] len);
    @(negedge clk);
    result_valid = 1;
    result_data = 24'h123456;
    status_byte = 8'h05;
    @(negedge clk);
    result_valid = 0;
    chk(result_ready, 1);
    chk(result_out.word, w);
    chk(result_out.length, len);
  endtask
  // =====================================================
  // Scenarios
  task automatic t_reset_and_fields();
    rd(OPT_ADDR, 24'h000000, 1);
    rd(8'h05, 24'h000000, 0);
    wr(16'hFFFF);
    rd(OPT_ADDR, 24'h0019EF, 1);
    chk({dout_reset_en, drive_strength}, 2'b11);
    for (int i = 0; i < 4; i++) begin
      wr(16'(i << 2));
      chk({extra_check_byte, write_check_crc}, {2{i != 0}});
      chk({read_check_xor, read_check_crc}, {i == 1, i >= 2});
    end
    $display("test reset_and_fields done");
  endtask
  task automatic t_readout_sync();
    wr(16'h1080);
    sync_pin = 1;
    chk(cont_readout_active, 1);
    adc_mode = 3'h1;
    repeat (5) @(negedge clk);
    chk(cont_readout_active, 0);
    chk({conversion_gate, sync_normal}, 2'b10);
    wr(16'h0000);
    @(negedge clk);
    chk({conversion_gate, sync_normal}, 2'b01);
    adc_mode = 3'h0;
    sync_pin = 0;
    $display("test readout_sync done");
  endtask
  task automatic t_integrity();
    @(negedge clk);
    ureg_wr = 1;
    ureg_d = 24'h001234;
    @(negedge clk);
    ureg_wr = 0;
    wr(16'h0020);
    rd(SIG_ADDR, 24'h0F1234, 1);
    wr(16'h0060);
    @(negedge clk);
    chk(integrity_error, 0);
    @(negedge clk);
    ureg_wr = 1;
    ureg_d = 24'h004321;
    @(negedge clk);
    ureg_wr = 0;
    @(negedge clk);
    chk(integrity_error, 1);
    wr(16'h0000);
    chk(integrity_error, 0);
    rd(SIG_ADDR, 24'h000000, 1);
    $display("test integrity done");
  endtask
  task automatic t_result();
    res(32'h00123456, 6'h18);
    wr(16'h0001);
    res(32'h00001234, 6'h10);
    wr(16'h0041);
    res(32'h00123405, 6'h18);
    wr(16'h0040);
    res(32'h12345605, 6'h20);
    $display("test result done");
  endtask
  task automatic t_mid_reset();
    wr(16'h0160);
    @(negedge clk);
    reset = 1;
    repeat (2) @(negedge clk);
    reset = 0;
    chk({dout_reset_en, integrity_error, result_out.length}, 8'h00);
    rd(OPT_ADDR, 24'h000000, 1);
    rd(SIG_ADDR, 24'h000000, 1);
    $display("test mid_reset done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // =====================================================
  // Main sequence and watchdog
  initial begin
    repeat (4) @(negedge clk);
    reset = 0;
    t_reset_and_fields();
    t_readout_sync();
    t_integrity();
    t_result();
    t_mid_reset();
    test_done();
  end
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule
